// file: src/iqs_top.sv
// i2c master acknowledge, stop and byte-transmit sequencer with axi4-lite registers
// assumes open-drain pads outside: a pin is pulled low while its _oe is high
`include "iqs_defines.svh"
`timescale 1ns/1ps
module iqs_top
    import iqs_pkg::*;
(
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // axi4-lite write
    input wire logic [31:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // axi4-lite read
    input wire logic [31:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // i2c pins
    input wire logic scl_i,
    output logic scl_o,
    output logic scl_oe,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe,
    // processor wake
    output logic wake_cpu
);

    // ----------------------------------------
    // state
    // ----------------------------------------
    iqs_state_t state;
    iqs_state_t next_state;
    logic [6:0] divider_reload_value;
    logic [6:0] bit_rate_counter;
    logic [7:0] serial_buffer;
    logic [7:0] tx_shift;
    logic [3:0] bit_idx;
    logic acknowledge_sequence_go, halt_sequence_go, ack_bit_value;
    logic port_enable, irq_enable, cpu_sleep, tx_pend, ack_rx;
    logic serial_port_irq_flag, write_collision_flag, halt_flag, begin_flag;
    logic scl_m, scl_s, sda_m, sda_s, sda_d, scl_d;
    logic [`IQS_ADDR_W-1:0] aw_addr;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic wr_fire, wr_lane, counting, tick;
    logic wr_con2, wr_buf, wr_div, wr_con1, wr_flag, buf_busy;

    // ----------------------------------------
    // pin synchronisers
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_m <= 1'b1;
            scl_s <= 1'b1;
            sda_m <= 1'b1;
            sda_s <= 1'b1;
            scl_d <= 1'b1;
            sda_d <= 1'b1;
        end else begin
            scl_m <= scl_i;
            scl_s <= scl_m;
            sda_m <= sda_i;
            sda_s <= sda_m;
            scl_d <= scl_s;
            sda_d <= sda_s;
        end
    end

    // ----------------------------------------
    // axi4-lite write channel
    // ----------------------------------------
    assign wr_fire = !awready && !wready && !bvalid;
    assign wr_lane = wr_fire && w_strb[0];
    assign wr_con2 = wr_lane && aw_addr == `IQS_OFF_CON2;
    assign wr_buf = wr_lane && aw_addr == `IQS_OFF_BUF;
    assign wr_div = wr_lane && aw_addr == `IQS_OFF_DIV;
    assign wr_con1 = wr_lane && aw_addr == `IQS_OFF_CON1;
    assign wr_flag = wr_lane && aw_addr == `IQS_OFF_FLAG;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            bvalid <= 1'b0;
            bresp <= `IQS_RESP_OKAY;
            aw_addr <= '0;
            w_data <= '0;
            w_strb <= '0;
        end else begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_addr <= awaddr[`IQS_ADDR_W-1:0];
            end
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_data <= wdata;
                w_strb <= wstrb;
            end
            if (wr_fire) begin
                bvalid <= 1'b1;
                // status register is read-only, so a write there is refused too
                bresp <= (aw_addr == `IQS_OFF_CON2 || aw_addr == `IQS_OFF_BUF ||
                          aw_addr == `IQS_OFF_DIV || aw_addr == `IQS_OFF_CON1 ||
                          aw_addr == `IQS_OFF_FLAG) ? `IQS_RESP_OKAY : `IQS_RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // ----------------------------------------
    // axi4-lite read channel
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= `IQS_RESP_OKAY;
        end else if (arvalid && arready) begin
            arready <= 1'b0;
            rvalid <= 1'b1;
            rdata <= '0;
            rresp <= `IQS_RESP_OKAY;
            case (araddr[`IQS_ADDR_W-1:0])
                `IQS_OFF_CON2: begin
                    rdata[`IQS_CON2_ACK_VAL] <= ack_bit_value;
                    rdata[`IQS_CON2_ACK_GO] <= acknowledge_sequence_go;
                    rdata[`IQS_CON2_HALT_GO] <= halt_sequence_go;
                end
                `IQS_OFF_STAT: begin
                    rdata[`IQS_STAT_HALT] <= halt_flag;
                    rdata[`IQS_STAT_BEGIN] <= begin_flag;
                    rdata[`IQS_STAT_ACK_RX] <= ack_rx;
                end
                `IQS_OFF_BUF: rdata[7:0] <= serial_buffer;
                `IQS_OFF_DIV: rdata[6:0] <= divider_reload_value;
                `IQS_OFF_CON1: begin
                    rdata[`IQS_CON1_ENABLE] <= port_enable;
                    rdata[`IQS_CON1_IRQ_EN] <= irq_enable;
                    rdata[`IQS_CON1_SLEEP] <= cpu_sleep;
                end
                `IQS_OFF_FLAG: begin
                    rdata[`IQS_FLAG_IRQ] <= serial_port_irq_flag;
                    rdata[`IQS_FLAG_WRITE_COLLISION_FLAG] <= write_collision_flag;
                end
                default: rresp <= `IQS_RESP_SLVERR;
            endcase
        end else if (rvalid && rready) begin
            rvalid <= 1'b0;
            arready <= 1'b1;
        end
    end

    // ----------------------------------------
    // control registers
    // ----------------------------------------
    // go bits only arm in idle; only clearing the port enable aborts a running sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            acknowledge_sequence_go <= 1'b0;
            halt_sequence_go <= 1'b0;
            ack_bit_value <= 1'b0;
            port_enable <= 1'b0;
            irq_enable <= 1'b0;
            cpu_sleep <= 1'b0;
            divider_reload_value <= `IQS_DIV_RESET;
        end else begin
            if (wr_con2) begin
                ack_bit_value <= w_data[`IQS_CON2_ACK_VAL];
                if (state == IQS_IDLE && w_data[`IQS_CON2_ACK_GO])
                    acknowledge_sequence_go <= 1'b1;
                if (state == IQS_IDLE && w_data[`IQS_CON2_HALT_GO])
                    halt_sequence_go <= 1'b1;
            end
            if (state == IQS_ACK_HIGH && next_state == IQS_IDLE)
                acknowledge_sequence_go <= 1'b0;
            if (state == IQS_STP_FIN && next_state == IQS_IDLE)
                halt_sequence_go <= 1'b0;
            if (!port_enable) begin
                acknowledge_sequence_go <= 1'b0;
                halt_sequence_go <= 1'b0;
            end
            if (wr_div)
                divider_reload_value <= w_data[6:0];
            if (wr_con1) begin
                port_enable <= w_data[`IQS_CON1_ENABLE];
                irq_enable <= w_data[`IQS_CON1_IRQ_EN];
                cpu_sleep <= w_data[`IQS_CON1_SLEEP];
            end
        end
    end

    // ----------------------------------------
    // buffer and collision
    // ----------------------------------------
    assign buf_busy = state != IQS_IDLE || acknowledge_sequence_go || halt_sequence_go || tx_pend;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            serial_buffer <= '0;
            tx_pend <= 1'b0;
            write_collision_flag <= 1'b0;
        end else begin
            if (wr_flag && w_data[`IQS_FLAG_WRITE_COLLISION_FLAG])
                write_collision_flag <= 1'b0;
            if (wr_buf && buf_busy)
                write_collision_flag <= 1'b1;
            else if (wr_buf && port_enable) begin
                serial_buffer <= w_data[7:0];
                tx_pend <= 1'b1;
            end
            if (state == IQS_IDLE && next_state == IQS_TX_LOW)
                tx_pend <= 1'b0;
            if (!port_enable)
                tx_pend <= 1'b0;
        end
    end

    // ----------------------------------------
    // bit rate counter
    // ----------------------------------------
    assign counting = state == IQS_ACK_LOW || state == IQS_ACK_HIGH || state == IQS_STP_CNT ||
                      state == IQS_STP_SDA_WAIT || state == IQS_STP_FIN ||
                      state == IQS_TX_LOW || state == IQS_TX_HIGH;
    assign tick = counting && bit_rate_counter == '0;

    // every state change reloads; release states are not counting, so the count stays frozen there
    always_ff @(posedge aclk) begin
        if (!aresetn)
            bit_rate_counter <= '0;
        else if (state != next_state)
            bit_rate_counter <= divider_reload_value;
        else if (counting && bit_rate_counter != '0)
            bit_rate_counter <= bit_rate_counter - 7'h01;
    end

    // ----------------------------------------
    // sequencer
    // ----------------------------------------
    always_comb begin
        next_state = state;
        case (state)
            IQS_IDLE: begin
                if (acknowledge_sequence_go)
                    next_state = IQS_ACK_LOW;
                else if (halt_sequence_go)
                    next_state = IQS_STP_SDA_LOW;
                else if (tx_pend)
                    next_state = IQS_TX_LOW;
            end
            IQS_ACK_LOW: if (tick) next_state = IQS_ACK_REL;
            IQS_ACK_REL: if (scl_s) next_state = IQS_ACK_HIGH;
            IQS_ACK_HIGH: if (tick) next_state = IQS_IDLE;
            IQS_STP_SDA_LOW: if (!sda_s) next_state = IQS_STP_CNT;
            IQS_STP_CNT: if (tick) next_state = IQS_STP_SCL_REL;
            IQS_STP_SCL_REL: if (scl_s) next_state = IQS_STP_SDA_WAIT;
            IQS_STP_SDA_WAIT: if (tick) next_state = IQS_STP_SDA_REL;
            IQS_STP_SDA_REL: if (sda_s && scl_s) next_state = IQS_STP_FIN;
            IQS_STP_FIN: if (tick) next_state = IQS_IDLE;
            IQS_TX_LOW: if (tick) next_state = IQS_TX_REL;
            IQS_TX_REL: if (scl_s) next_state = IQS_TX_HIGH;
            IQS_TX_HIGH: begin
                if (tick)
                    next_state = (bit_idx == `IQS_LAST_BIT) ? IQS_IDLE : IQS_TX_LOW;
            end
            default: next_state = IQS_IDLE;
        endcase
        if (!port_enable)
            next_state = IQS_IDLE;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn)
            state <= IQS_IDLE;
        else
            state <= next_state;
    end

    // transmit shifter: eight data bits, then a ninth with sda released for ack
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tx_shift <= '0;
            bit_idx <= '0;
            ack_rx <= 1'b0;
        end else if (state == IQS_IDLE && next_state == IQS_TX_LOW) begin
            tx_shift <= serial_buffer;
            bit_idx <= '0;
        end else if (state == IQS_TX_HIGH && tick) begin
            tx_shift <= {tx_shift[6:0], 1'b0};
            bit_idx <= bit_idx + 4'h1;
            if (bit_idx == `IQS_LAST_BIT)
                ack_rx <= sda_s;
        end
    end

    // ----------------------------------------
    // pin drivers
    // ----------------------------------------
    // entering idle from ack or byte end pulls scl low again, so scl stays low between bytes
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (!port_enable) begin
            scl_oe <= 1'b0;
            sda_oe <= 1'b0;
        end else if (state != next_state) begin
            case (next_state)
                IQS_ACK_LOW: begin
                    scl_oe <= 1'b1;
                    sda_oe <= !ack_bit_value;
                end
                IQS_STP_SDA_LOW: begin
                    scl_oe <= 1'b1;
                    sda_oe <= 1'b1;
                end
                IQS_TX_LOW: begin
                    scl_oe <= 1'b1;
                    sda_oe <= (state == IQS_IDLE) ? !serial_buffer[7] :
                              (bit_idx == `IQS_LAST_BIT - 4'h1) ? 1'b0 : !tx_shift[6];
                end
                IQS_ACK_REL, IQS_TX_REL, IQS_STP_SCL_REL: scl_oe <= 1'b0;
                IQS_STP_SDA_REL: sda_oe <= 1'b0;
                IQS_IDLE: begin
                    if (state == IQS_ACK_HIGH || state == IQS_TX_HIGH)
                        scl_oe <= 1'b1;
                    if (state == IQS_ACK_HIGH)
                        sda_oe <= 1'b0;
                end
                default: begin
                    scl_oe <= scl_oe;
                    sda_oe <= sda_oe;
                end
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end else begin
            scl_o <= 1'b0;
            sda_o <= 1'b0;
        end
    end

    // ----------------------------------------
    // status flags and wake
    // ----------------------------------------
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            halt_flag <= 1'b0;
            begin_flag <= 1'b0;
            serial_port_irq_flag <= 1'b0;
            wake_cpu <= 1'b0;
        end else begin
            if (!port_enable) begin
                halt_flag <= 1'b0;
                begin_flag <= 1'b0;
            end else if (state == IQS_STP_SDA_REL && next_state == IQS_STP_FIN) begin
                halt_flag <= 1'b1;
                begin_flag <= 1'b0;
            end else if (scl_s && scl_d && sda_d && !sda_s) begin
                begin_flag <= 1'b1;
                halt_flag <= 1'b0;
            end
            if (wr_flag && w_data[`IQS_FLAG_IRQ])
                serial_port_irq_flag <= 1'b0;
            if ((state == IQS_STP_FIN || state == IQS_TX_HIGH) && next_state == IQS_IDLE &&
                port_enable)
                serial_port_irq_flag <= 1'b1;
            wake_cpu <= cpu_sleep && irq_enable && serial_port_irq_flag;
        end
    end

    // ----------------------------------------
    // assertions
    // ----------------------------------------
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    chk_ack_go_start: assert property ($rose(acknowledge_sequence_go) && state == IQS_IDLE |=>
        state == IQS_ACK_LOW) else $error("ack go did not start sequence");
    chk_ack_pins: assert property (state == IQS_ACK_LOW |->
        scl_oe && sda_oe == !ack_bit_value) else $error("ack pins wrong");
    chk_ack_release: assert property (state == IQS_ACK_LOW && tick |=>
        !scl_oe && state == IQS_ACK_REL) else $error("scl not released after low time");
    chk_ack_relow: assert property (state == IQS_ACK_HIGH && tick |=>
        scl_oe && state == IQS_IDLE) else $error("scl not pulled low after high time");
    chk_ack_go_clear: assert property ($fell(acknowledge_sequence_go) && port_enable |->
        state == IQS_IDLE && !counting) else $error("ack go cleared outside idle");
    chk_write_collision_flag_buf: assert property (wr_buf && buf_busy |=>
        write_collision_flag && $stable(serial_buffer)) else $error("collision not handled");
    chk_hold_scl: assert property ($past(state) == IQS_TX_HIGH && state == IQS_IDLE &&
        port_enable |-> scl_oe [*2]) else $error("scl not held after ninth clock");
    chk_stop_sda_low: assert property (state == IQS_STP_SDA_LOW |-> sda_oe && scl_oe)
        else $error("stop did not drive sda low");
    chk_stop_reload: assert property (state == IQS_STP_SDA_LOW && !sda_s && port_enable |=>
        bit_rate_counter == divider_reload_value) else $error("counter not reloaded on sda low");
    chk_stop_release: assert property (state == IQS_STP_CNT && tick && port_enable |=>
        !scl_oe && sda_oe) else $error("scl release order wrong");
    chk_halt_flag: assert property ($rose(halt_flag) |->
        $past(sda_s) && $past(scl_s)) else $error("halt flag without stop level");
    chk_stop_finish: assert property ($rose(halt_flag) |-> ##[1:130]
        (!halt_sequence_go && serial_port_irq_flag)) else $error("stop did not finish");
    chk_brg_freeze: assert property ((state == IQS_TX_REL || state == IQS_ACK_REL) && !scl_s &&
        port_enable |=> $stable(bit_rate_counter)) else $error("counter ran while scl low");
    chk_brg_reload: assert property (state == IQS_TX_REL && scl_s && port_enable |=>
        bit_rate_counter == divider_reload_value) else $error("counter not reloaded on scl high");
    chk_wake_cpu: assert property (cpu_sleep && irq_enable && serial_port_irq_flag |=>
        wake_cpu) else $error("wake not raised");
    chk_flag_sticky: assert property (serial_port_irq_flag && !wr_flag |=>
        serial_port_irq_flag) else $error("irq flag cleared by hardware");
    chk_reset_idle: assert property (@(posedge aclk) disable iff (1'b0) !aresetn |=>
        state == IQS_IDLE && !scl_oe && !sda_oe) else $error("reset did not abort");

    cov_ack_done: cover property (state == IQS_ACK_HIGH ##1 state == IQS_IDLE);
    cov_stop_done: cover property (state == IQS_STP_FIN ##1 state == IQS_IDLE);
    cov_byte_done: cover property (state == IQS_TX_HIGH && bit_idx == `IQS_LAST_BIT && tick);
    cov_write_collision_flag: cover property (wr_buf && buf_busy);

endmodule : iqs_top

// file: src/iqs_defines.svh
// constants for the i2c acknowledge / stop sequencer
// assumes an axi4-lite master with 32-bit data and a 25 MHz aclk
//
// Contract
// - ack go bit at control bit 4 starts ack
// - ack drives scl low, ack value on sda
// - one rollover with scl low, then release scl
// - scl sampled high, one rollover, scl low
// - ack end clears go, stops counter, idles
// - buffer write during ack sets collision, dropped
// - scl held low after ninth clock falls
// - halt go bit at control bit 2 drives sda low
// - sda sampled low reloads counter, counts down
// - timeout releases scl, rollover later releases sda
// - halt flag status bit 4 on sda/scl high
// - rollover after halt flag: clear go, set irq
// - buffer write during stop sets collision, dropped
// - released scl freezes counter until sampled high
// - scl high reloads counter from 7-bit divider
// - completed byte during sleep wakes cpu if enabled
// - reset disables port, aborts transfer
`ifndef IQS_DEFINES_SVH
`define IQS_DEFINES_SVH

`define IQS_ADDR_W 12
`define IQS_OFF_CON2 12'h000
`define IQS_OFF_STAT 12'h004
`define IQS_OFF_BUF 12'h008
`define IQS_OFF_DIV 12'h00C
`define IQS_OFF_CON1 12'h010
`define IQS_OFF_FLAG 12'h014

`define IQS_CON2_HALT_GO 2
`define IQS_CON2_ACK_GO 4
`define IQS_CON2_ACK_VAL 5
`define IQS_STAT_ACK_RX 0
`define IQS_STAT_BEGIN 3
`define IQS_STAT_HALT 4
`define IQS_CON1_ENABLE 0
`define IQS_CON1_IRQ_EN 1
`define IQS_CON1_SLEEP 2
`define IQS_FLAG_IRQ 0
`define IQS_FLAG_WRITE_COLLISION_FLAG 1

`define IQS_DIV_RESET 7'h7F
`define IQS_LAST_BIT 4'h8
`define IQS_RESP_OKAY 2'h0
`define IQS_RESP_SLVERR 2'h2

`endif

// file: src/iqs_pkg.sv
// types for the i2c acknowledge / stop sequencer
// assumes iqs_defines.svh supplies the numeric constants
package iqs_pkg;
    typedef enum logic [3:0] {
        IQS_IDLE = 4'h0,
        IQS_ACK_LOW = 4'h1,
        IQS_ACK_REL = 4'h2,
        IQS_ACK_HIGH = 4'h3,
        IQS_STP_SDA_LOW = 4'h4,
        IQS_STP_CNT = 4'h5,
        IQS_STP_SCL_REL = 4'h6,
        IQS_STP_SDA_WAIT = 4'h7,
        IQS_STP_SDA_REL = 4'h8,
        IQS_STP_FIN = 4'h9,
        IQS_TX_LOW = 4'hA,
        IQS_TX_REL = 4'hB,
        IQS_TX_HIGH = 4'hC
    } iqs_state_t;
endpackage : iqs_pkg

// file: test/iqs_slave_model.sv
// i2c slave model: stretches scl after each release, acks each byte
// assumes open-drain wires with pull-ups
`timescale 1ns/1ps
module iqs_slave_model (
    // clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // bus
    input wire logic scl_oe,
    input wire logic sda_oe,
    input wire logic [3:0] stretch,
    output logic scl_w,
    output logic sda_w,
    output logic [7:0] rx_byte
);
    logic [3:0] hold;
    logic [3:0] nbit;
    logic ack_low;
    logic scl_q;
    logic sda_q;
    // pull-ups: a released wire reads high
    assign scl_w = !(scl_oe || hold != 4'h0);
    assign sda_w = !(sda_oe || ack_low);
    // hold is reset so scl reads a clean high before the first sequence
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            hold <= 4'h0;
            scl_q <= 1'b1;
            sda_q <= 1'b1;
            rx_byte <= 8'h00;
            nbit <= 4'h0;
            ack_low <= 1'b0;
        end else begin
            scl_q <= scl_w;
            sda_q <= sda_w;
            hold <= scl_oe ? stretch : (hold != 4'h0 ? hold - 4'h1 : 4'h0);
            if (scl_w && !scl_q && nbit < 4'h8) rx_byte <= {rx_byte[6:0], sda_w};
            if (scl_w && !scl_q) nbit <= nbit + 4'h1;
            if (!scl_w && scl_q) ack_low <= (nbit == 4'h8);
            if (!scl_w && scl_q && nbit == 4'h9) nbit <= 4'h0;
            // a stop restarts the bit count
            if (scl_w && sda_w && !sda_q) nbit <= 4'h0;
        end
    end
endmodule : iqs_slave_model

// file: test/test_iqs_top.sv
// bench for the sequencer: axi4-lite master, slave model on the wires
// assumes DIV=2, so one rollover is 3 aclk cycles
`timescale 1ns/1ps
module test_iqs_top;
    logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] awaddr = 0, wdata = 0, araddr = 0, rdata, d, qe[$], qm[$];
    logic [3:0] wstrb = 4'hF, stretch = 4'h4;
    logic awready, wready, bvalid, arready, rvalid, scl_o, scl_oe, sda_o, sda_oe;
    logic wake_cpu, scl_w, sda_w;
    logic [1:0] bresp, rresp;
    logic [7:0] rx_byte, rnd = 8'h1D;
    int error_cnt = 0, check_count = 0, n;
    always #20 aclk = ~aclk;
    iqs_top dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid,
        .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp,
        .rvalid, .rready, .scl_i(scl_w), .scl_o, .scl_oe, .sda_i(sda_w), .sda_o, .sda_oe,
        .wake_cpu);
    iqs_slave_model partner (.aclk, .aresetn, .scl_oe, .sda_oe, .stretch, .scl_w, .sda_w,
        .rx_byte);
    function automatic [7:0] lfsr(input [7:0] x);
        return {x[6:0], x[7] ^ x[5] ^ x[4] ^ x[3]};
    endfunction : lfsr
    task check(input [31:0] seen, input [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task wr(input [11:0] a, input [31:0] v, input [1:0] er);
        @(posedge aclk);
        awaddr <= {20'h0, a};
        wdata <= v;
        {awvalid, wvalid, bready} <= 3'h7;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (!bvalid);
        bready <= 1'b0;
        check(bresp, er);
    endtask : wr
    // mask 0 marks a poll whose data is not compared
    task rd(input [11:0] a, input [31:0] e, input [31:0] m);
        qe.push_back(e);
        qm.push_back(m);
        @(posedge aclk);
        araddr <= {20'h0, a};
        {arvalid, rready} <= 2'h3;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (!rvalid);
        d = rdata;
        rready <= 1'b0;
    endtask : rd
    always @(posedge aclk) begin
        if (rvalid && rready) begin
            if (qm[0] != 0) check(rdata & qm[0], qe[0]);
            void'(qe.pop_front());
            void'(qm.pop_front());
        end
    end
    task automatic waitfor(ref logic s, input logic v);
        for (n = 0; n < 600 && s !== v; n++) @(posedge aclk);
        check(s, v);
    endtask : waitfor
    task poll(input [11:0] a, input [31:0] m, input [31:0] e);
        for (int i = 0; i < 100; i++) begin
            rd(a, 0, 0);
            if ((d & m) == e) break;
        end
        check(d & m, e);
    endtask : poll
    task end_of_test;
        $display("checks=%0d errors=%0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial begin
        #(40 * 20000);
        error_cnt++;
        end_of_test;
    end
    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rd(12'h00C, 32'h7F, '1);
        rd(12'h020, 32'h0, '1);
        check(rresp, 2'h2);
        wr(12'h004, 32'h10, 2'h2);
        // port still disabled: buffer write is dropped, buffer stays 0
        wr(12'h008, 32'h5A, 0);
        wr(12'h00C, 32'h2, 0);
        wr(12'h010, 32'h1, 0);
        rd(12'h004, 0, 32'h18);
        for (int v = 0; v < 2; v++) begin
            wr(12'h000, v << 5, 0);
            wr(12'h000, (v << 5) | 32'h10, 0);
            waitfor(scl_oe, 1);
            check(sda_oe, v == 0);
            if (v) wr(12'h008, 32'hA5, 0);
            waitfor(scl_oe, 0);
            if (!v) check(n, 3);
            waitfor(scl_oe, 1);
            if (!v) check(n >= 7, 1);
            rd(12'h000, v << 5, '1);
        end
        $display("ack done");
        wr(12'h000, 32'h04, 0);
        waitfor(sda_oe, 1);
        check(scl_oe, 1);
        wr(12'h008, 32'h33, 0);
        waitfor(scl_oe, 0);
        check(sda_oe, 1);
        waitfor(sda_oe, 0);
        check(n >= 7, 1);
        poll(12'h000, 32'h04, 0);
        rd(12'h004, 32'h10, 32'h10);
        rd(12'h014, 32'h3, '1);
        rd(12'h008, 32'h0, 32'hFF);
        $display("stop done");
        wr(12'h010, 32'h7, 0);
        waitfor(wake_cpu, 1);
        wr(12'h014, 32'h3, 0);
        waitfor(wake_cpu, 0);
        rnd = lfsr(rnd);
        wr(12'h008, {24'h0, rnd}, 0);
        poll(12'h014, 32'h1, 32'h1);
        check(rx_byte, rnd);
        check(wake_cpu, 1);
        check(scl_oe, 1);
        rd(12'h004, 0, 32'h1);
        $display("byte done");
        wr(12'h000, 32'h10, 0);
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        check({scl_o, sda_o, scl_oe, sda_oe}, 0);
        rd(12'h010, 0, '1);
        rd(12'h000, 0, '1);
        $display("reset done");
        end_of_test;
    end
endmodule : test_iqs_top
